/* File: hdl/timer16_regs.vh */
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

// Register addresses in the CPU memory map
`define MODE_CTRL_ADDR 16'hFF7E
`define SECOND_CC_ADDR 16'hFF14

// Mode control field positions
`define MODE_HI_BIT 3
`define MODE_LO_BIT 2
`define TOGGLE_SEL_BIT 1
`define OVF_BIT 0

// Reset values
`define MODE_CTRL_RESET 8'h00
`define SECOND_CC_RESET 16'h0000

// Operating modes
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_CLR_EDGE 2'h2
`define MODE_CLR_MATCH 2'h3

// Edge select codes
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_NONE 2'h2
`define EDGE_BOTH 2'h3

`endif

/* File: hdl/pin_edge_detect.v */
`include "timer16_regs.vh"
`default_nettype none

module pin_edge_detect (
  input wire sys_clk,
  input wire rstn,
  input wire pin,
  input wire [1:0] edge_sel,
  output reg valid_edge
);

  reg meta_q;
  reg sync_q;
  reg last_q;
  reg [2:0] prime_q;

  // Edges are masked until the pipe holds real pin samples, so a pin
  // idling high gives no false edge after reset
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      prime_q <= 3'h0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // Pattern 10 is prohibited; treated as no edge
  always @* begin
    case (edge_sel)
      `EDGE_FALL: valid_edge = last_q & ~sync_q;
      `EDGE_RISE: valid_edge = ~last_q & sync_q;
      `EDGE_BOTH: valid_edge = last_q ^ sync_q;
      default: valid_edge = 1'b0;
    endcase
    if (!prime_q[2]) begin
      valid_edge = 1'b0;
    end
  end

endmodule // pin_edge_detect

`default_nettype wire

/* File: hdl/timer16_cc1_and_mode_control.v */
// Summary of operation
// - Second register role set by the second_reg_mode_select input
// - Select 0 compare, 1 capture
// - Reset clears second register to zero
// - Compare continuously, irq on equality, hold value
// - Capture on selected input edge, 00/01/11
// - Zero compare fires after overflow or clear
// - Read/capture clash may return undefined data
// - Second register writable while counting
// - Mode register resets zero, byte/bit writable
// - Nonzero mode bits start, zero stops
// - Mode bits: stop, free, clear-edge, clear-match
// - Toggle select bit adds input edge
// - Match interrupts only while running
// - Bit 0 reads overflow detected
// - Wrap from all ones sets overflow
`include "timer16_regs.vh"
`default_nettype none

module timer16_cc1_and_mode_control #(
  parameter WIDTH = 16
) (
  input wire sys_clk,
  input wire rstn,
  input wire count_tick,
  input wire [15:0] mem_addr,
  input wire mem_wr,
  input wire mem_rd,
  input wire mem_word,
  input wire [15:0] mem_wdata,
  output reg [15:0] mem_rdata,
  input wire second_reg_mode_select,
  input wire input_edge_sel_hi,
  input wire input_edge_sel_lo,
  input wire [WIDTH-1:0] first_capture_compare,
  input wire one_shot_trigger,
  input wire first_timer_input,
  output reg [WIDTH-1:0] timer_count,
  output reg second_match_irq,
  output reg first_match_irq,
  output reg output_toggle_req,
  output wire overflow_flag
);

  reg [7:0] mode_q;
  reg [7:0] mode_d;
  reg [WIDTH-1:0] second_cc_q;
  reg [WIDTH-1:0] second_cc_d;
  reg edge_pend_q;
  reg [15:0] rdata_d;
  wire valid_edge;
  wire [1:0] mode;
  wire running;
  wire capture_mode;
  wire wr_mode;
  wire wr_cc;
  wire at_max;
  wire match0;
  wire match1;
  wire clr_now;
  wire edge_evt;
  wire ovf_set;
  wire capture_load;
  wire second_hit;
  wire first_hit;
  wire toggle_hit;

  // Address decode shared by the write and read paths
  function is_mode_addr(input [15:0] addr);
    is_mode_addr = (addr == `MODE_CTRL_ADDR);
  endfunction

  function is_cc_addr(input [15:0] addr);
    is_cc_addr = (addr == `SECOND_CC_ADDR);
  endfunction

  pin_edge_detect u_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(first_timer_input),
    .edge_sel({input_edge_sel_hi, input_edge_sel_lo}),
    .valid_edge(valid_edge)
  );

  assign mode = {mode_q[`MODE_HI_BIT], mode_q[`MODE_LO_BIT]};
  assign running = (mode != `MODE_STOP);
  assign capture_mode = second_reg_mode_select;
  assign wr_mode = mem_wr && is_mode_addr(mem_addr);

  // Byte writes to the word register are dropped
  assign wr_cc = mem_wr && mem_word && is_cc_addr(mem_addr);

  assign at_max = (timer_count == {WIDTH{1'b1}});
  assign match0 = (timer_count == first_capture_compare);
  assign match1 = (timer_count == second_cc_q) && !capture_mode;
  assign edge_evt = edge_pend_q | valid_edge;
  assign overflow_flag = mode_q[`OVF_BIT];

  // Any running tick at all ones counts as a wrap, whether the counter increments or clears
  assign ovf_set = running && count_tick && at_max;

  // A capture racing a stop write may store a stale count
  assign capture_load = capture_mode && running && valid_edge;

  // Clear decided at the tick so edges between ticks are not lost
  assign clr_now = one_shot_trigger
                 || ((mode == `MODE_CLR_EDGE) && edge_evt)
                 || ((mode == `MODE_CLR_MATCH) && match0);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      edge_pend_q <= 1'b0;
    end else if (!running || count_tick) begin
      edge_pend_q <= 1'b0;
    end else if (valid_edge) begin
      edge_pend_q <= 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_count <= {WIDTH{1'b0}};
    end else if (!running) begin
      timer_count <= {WIDTH{1'b0}};
    end else if (count_tick) begin
      if (clr_now) begin
        timer_count <= {WIDTH{1'b0}};
      end else begin
        timer_count <= timer_count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Compare events are sampled on the tick, one per counter value; after a
  // clear or wrap the counter sits at zero, so a zero compare fires then
  assign second_hit = running && count_tick && match1;
  assign first_hit = running && count_tick && match0;
  assign toggle_hit = running && ((count_tick && (match0 || match1))
                    || (mode_q[`TOGGLE_SEL_BIT] && valid_edge));

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      second_match_irq <= 1'b0;
      first_match_irq <= 1'b0;
      output_toggle_req <= 1'b0;
    end else begin
      second_match_irq <= second_hit;
      first_match_irq <= first_hit;
      output_toggle_req <= toggle_hit;
    end
  end

  // Capture has priority over a coinciding software write
  always @* begin
    second_cc_d = second_cc_q;
    if (capture_load) begin
      second_cc_d = timer_count;
    end else if (wr_cc) begin
      second_cc_d = mem_wdata[WIDTH-1:0];
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      second_cc_q <= `SECOND_CC_RESET;
    end else begin
      second_cc_q <= second_cc_d;
    end
  end

  // Mode bits are written unguarded: stopping first is software's duty
  always @* begin
    mode_d = mode_q;
    if (wr_mode) begin
      mode_d[`MODE_HI_BIT:`TOGGLE_SEL_BIT] = mem_wdata[`MODE_HI_BIT:`TOGGLE_SEL_BIT];
    end
    // Wrap sets the flag and wins over a clearing write
    if (ovf_set) begin
      mode_d[`OVF_BIT] = 1'b1;
    end else if (wr_mode && !mem_wdata[`OVF_BIT]) begin
      mode_d[`OVF_BIT] = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `MODE_CTRL_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Read during a capture returns the pre-capture value
  always @* begin
    rdata_d = 16'h0000;
    if (is_mode_addr(mem_addr)) begin
      rdata_d = {8'h00, mode_q};
    end else if (is_cc_addr(mem_addr)) begin
      rdata_d = second_cc_q;
    end
  end

  // Data holds between reads
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_rdata <= 16'h0000;
    end else if (mem_rd) begin
      mem_rdata <= rdata_d;
    end
  end

endmodule // timer16_cc1_and_mode_control

`default_nettype wire

/* File: verification/edge_source.sv */
`default_nettype none
module edge_source (
  input wire logic sys_clk,
  input wire logic lvl,
  output logic pin = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin moves off the clock edge
  always @(posedge sys_clk) pin <= #13 lvl;
endmodule // edge_source
`default_nettype wire

/* File: verification/timer16_cc1_sva.sv */
`default_nettype none
module timer16_cc1_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic count_tick,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] timer_count,
  input wire logic second_match_irq,
  input wire logic overflow_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence wrap_s;
    count_tick && !mem_wr && timer_count == 16'hFFFF ##1 timer_count == 16'h0000;
  endsequence
  rst_clear_a: assert property ($rose(rstn) |-> timer_count == 16'h0000)
    else $error("count not clear");
  irq_pulse_a: assert property (second_match_irq |=> !second_match_irq)
    else $error("irq too long");
  irq_tick_a: assert property (second_match_irq |-> $past(count_tick))
    else $error("irq without tick");
  count_hold_a: assert property (!count_tick && !mem_wr |=> $stable(timer_count))
    else $error("count moved");
  ovf_wrap_a: assert property (wrap_s |-> ##[0:1] overflow_flag)
    else $error("wrap not flagged");
  ovf_sticky_a: assert property ($fell(overflow_flag) |->
    $past(mem_wr && mem_addr == 16'hFF7E && !mem_wdata[0])) else $error("flag lost");
  ovf_set_a: assert property ((mem_wr && mem_addr == 16'hFF7E && mem_wdata[0] &&
    !overflow_flag && !count_tick) |=> !overflow_flag) else $error("flag set by write");
  mode_read_a: assert property (mem_rd && mem_addr == 16'hFF7E |=>
    mem_rdata[7:4] == 4'h0 && mem_rdata[0] == $past(overflow_flag)) else $error("bad read");
endmodule // timer16_cc1_sva
bind timer16_cc1_and_mode_control timer16_cc1_sva u_timer16_cc1_sva (.sys_clk, .rstn,
  .count_tick, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata, .timer_count,
  .second_match_irq, .overflow_flag);
`default_nettype wire

/* File: verification/tb_timer16_cc1_and_mode_control.sv */
`default_nettype none
module tb_timer16_cc1_and_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rstn = 0, count_tick = 0, mem_wr = 0, mem_rd = 0, mem_word = 0;
  logic sel = 0, es_hi = 0, es_lo = 0, lvl = 1, pin, irq, ovf, irq1, tgl;
  logic [15:0] mem_addr = 0, mem_wdata = 0, mem_rdata, timer_count, v, fcc = 16'hFFFF;
  logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  logic starts [4] = '{1, 0, 1, 1};
  int mismatches = 0, total_checks = 0;
  always #20 sys_clk = ~sys_clk;
  edge_source u_edge_source (.sys_clk, .lvl, .pin);
  timer16_cc1_and_mode_control u_timer16_cc1_and_mode_control (.sys_clk, .rstn, .count_tick,
    .mem_addr, .mem_wr, .mem_rd, .mem_word, .mem_wdata, .mem_rdata, .timer_count,
    .second_reg_mode_select(sel), .input_edge_sel_hi(es_hi), .input_edge_sel_lo(es_lo),
    .first_capture_compare(fcc), .one_shot_trigger(1'b0), .first_timer_input(pin),
    .second_match_irq(irq), .first_match_irq(irq1), .output_toggle_req(tgl),
    .overflow_flag(ovf));
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, d, input logic w);
    @(posedge sys_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_word <= w;
    mem_wr <= 1;
    @(posedge sys_clk);
    mem_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    mem_addr <= a;
    mem_rd <= 1;
    @(posedge sys_clk);
    mem_rd <= 0;
    @(negedge sys_clk);
    v = mem_rdata;
  endtask
  task automatic wait_for(ref logic s, input int n);
    repeat (n) if (s !== 1'b1) @(negedge sys_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1;
    rd(16'hFF7E);
    chk("mode", 16'h0000, v);
    rd(16'hFF14);
    chk("second", 16'h0000, v);
    wr(16'hFF7E, 16'h0001, 0);
    rd(16'hFF7E);
    chk("flag", 16'h0000, v);
    wr(16'hFF14, 16'h1234, 0);
    rd(16'hFF14);
    chk("byte", 16'h0000, v);
    wr(16'hFF14, 16'h0005, 1);
    count_tick <= 1;
    wr(16'hFF7E, 16'h0004, 0);
    wait_for(irq, 20);
    chk("match", 16'h0006, timer_count);
    wr(16'hFF14, 16'h0030, 1);
    wait_for(irq, 60);
    chk("rewrite", 16'h0031, timer_count);
    @(posedge sys_clk);
    count_tick <= 0;
    sel <= 1;
    for (int k = 0; k < 4; k++) begin
      {es_hi, es_lo} <= codes[k];
      lvl <= starts[k];
      repeat (6) @(posedge sys_clk);
      wr(16'hFF14, 16'hAAAA, 1);
      lvl <= ~starts[k];
      repeat (6) @(posedge sys_clk);
      rd(16'hFF14);
      chk("capture", k < 3 ? 16'h0032 : 16'hAAAA, v);
    end
    @(posedge sys_clk);
    sel <= 0;
    count_tick <= 1;
    wait_for(ovf, 70000);
    rd(16'hFF7E);
    chk("overflow", 16'h0005, v);
    wr(16'hFF7E, 16'h0004, 0);
    rd(16'hFF7E);
    chk("flag clear", 16'h0004, v);
    wr(16'hFF7E, 16'h0000, 0);
    fcc <= 16'h0010;
    repeat (3) @(negedge sys_clk);
    chk("stop", 16'h0000, timer_count);
    wr(16'hFF7E, 16'h000C, 0);
    repeat (40) @(negedge sys_clk);
    chk("clear match", 16'h0001, {15'h0000, timer_count <= 16'h0010});
    wr(16'hFF7E, 16'h0000, 0);
    {es_hi, es_lo} <= 2'h1;
    wr(16'hFF7E, 16'h0008, 0);
    repeat (30) @(posedge sys_clk);
    lvl <= 1;
    repeat (7) @(negedge sys_clk);
    chk("clear edge", 16'h0001, {15'h0000, timer_count < 16'h0008});
    wr(16'hFF7E, 16'h0000, 0);
    wr(16'hFF14, 16'h0000, 1);
    wr(16'hFF7E, 16'h000C, 0);
    wait_for(irq, 40);
    chk("zero match", 16'h0001, timer_count);
    wait_for(irq1, 40);
    chk("first match", 16'h0000, timer_count);
    wr(16'hFF7E, 16'h0000, 0);
    {es_hi, es_lo} <= 2'h3;
    lvl <= 0;
    repeat (12) begin
      @(negedge sys_clk);
      chk("stop quiet", 16'h0000, {14'h0000, tgl, irq});
    end
    conclude();
  end
endmodule // tb_timer16_cc1_and_mode_control
`default_nettype wire
